//--- src/fullduplex_link_framer.sv
// Purpose: full-duplex character link framer: packets out from the
//          message source, packets in to the message sink, responses
//          multiplexed into the outgoing character stream
// Assumes: crc_mode and parity_en are steady while a packet is open
// Notes:   message bytes reach the sink as they arrive; the sink must
//          drop a message that ends with pkt_bad
`timescale 1ns/1ps
module fullduplex_link_framer
  import link_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       reset_n,
  input  wire logic       proto_full,
  input  wire logic       crc_mode,
  input  wire logic       parity_en,
  input  wire logic       ser_rx,
  output logic            ser_tx,
  input  wire logic       src_valid,
  input  wire logic [7:0] src_data,
  input  wire logic       src_last,
  output logic            src_ready,
  input  wire logic       sink_full,
  output logic            snk_valid,
  output logic [7:0]      snk_data,
  output logic            pkt_good,
  output logic            pkt_bad,
  output logic            res_valid,
  output logic            res_ack,
  output logic            tx_wait
);

  typedef struct packed {
    tx_state_t   ts;
    rx_state_t   rs;
    logic        wait_res;
    logic        rsp_pend;
    logic        rsp_half;
    logic [7:0]  rsp_code;
    logic [7:0]  rsp_out;
    logic [7:0]  last_rsp;
    logic        tx_last;
    logic [7:0]  tx_sum;
    logic [15:0] tx_crc;
    logic [7:0]  rx_sum;
    logic [15:0] rx_crc;
    logic [7:0]  rx_len;
    logic        rx_ovf;
    logic        rx_bad;
    logic [7:0]  chk_lo;
    logic        snk_valid;
    logic [7:0]  snk_data;
    logic        pkt_good;
    logic        pkt_bad;
    logic        res_valid;
    logic        res_ack;
  } fr_t;

  localparam fr_t FR_RST = '{ts: T_IDLE, rs: R_IDLE, rsp_code: RSP_INIT,
                             rsp_out: RSP_INIT, last_rsp: RSP_INIT,
                             default: '0};

  fr_t         s_r;
  fr_t         s_nxt;
  logic        ch_valid;
  logic [7:0]  ch_data;
  logic        ch_ready;
  logic        take;
  logic        rx_valid;
  logic [7:0]  rx_data;
  logic        rx_err;

  // ---------------------------------------------------------------
  // receive helpers
  // ---------------------------------------------------------------
  // one payload byte into the message and both checks
  function automatic fr_t rx_pay(fr_t x, logic [7:0] b);
    if (x.rx_len == MSG_MAX) begin
      x.rx_ovf = 1'b1;
    end else begin
      x.rx_len    = x.rx_len + 8'h01;
      x.snk_valid = 1'b1;
      x.snk_data  = b;
    end
    x.rx_sum = x.rx_sum + b;
    x.rx_crc = crc_upd(x.rx_crc, b);
    return x;
  endfunction

  // response or enquiry seen on the line, never stored as payload
  function automatic fr_t rx_rsp(fr_t x, logic [7:0] b);
    if (is_resp(b) && x.wait_res) begin
      x.wait_res  = 1'b0;
      x.res_valid = 1'b1;
      x.res_ack   = (b == CH_ACK);
    end else if (b == CH_ENQ) begin
      x.rsp_pend = 1'b1;
      x.rsp_code = x.last_rsp;
    end
    return x;
  endfunction

  // close a received packet and queue the verdict
  function automatic fr_t rx_end(fr_t x, logic ok, logic full);
    logic good;
    good = ok && !x.rx_bad && !x.rx_ovf && !full &&
           (x.rx_len >= MSG_MIN);
    x.pkt_good = good;
    x.pkt_bad  = !good;
    x.rsp_pend = 1'b1;
    x.rsp_code = good ? CH_ACK : CH_NAK;
    x.rs       = R_IDLE;
    return x;
  endfunction

  // ---------------------------------------------------------------
  // next state: transmitter first, then receiver so that a new
  // response request wins over the one being consumed
  // ---------------------------------------------------------------
  always_comb begin
    s_nxt    = s_r;
    ch_valid = 1'b0;
    ch_data  = 8'h00;
    take     = 1'b0;
    s_nxt.snk_valid = 1'b0;
    s_nxt.pkt_good  = 1'b0;
    s_nxt.pkt_bad   = 1'b0;
    s_nxt.res_valid = 1'b0;
    // responses only enter between whole codes
    if ((s_r.rsp_pend || s_r.rsp_half) &&
        (s_r.ts inside {T_IDLE, T_SOP1, T_DATA, T_EOP1})) begin
      ch_valid = 1'b1;
      ch_data  = s_r.rsp_half ? s_r.rsp_out : CH_DLE;
      if (ch_ready) begin
        if (s_r.rsp_half) begin
          s_nxt.rsp_half = 1'b0;
          s_nxt.last_rsp = s_r.rsp_out;
        end else begin
          s_nxt.rsp_half = 1'b1;
          s_nxt.rsp_pend = 1'b0;
          s_nxt.rsp_out  = s_r.rsp_code;
        end
      end
    end else begin
      case (s_r.ts)
        T_IDLE: begin
          if (proto_full && src_valid && !s_r.wait_res) begin
            s_nxt.ts     = T_SOP1;
            s_nxt.tx_sum = SUM_INIT;
            s_nxt.tx_crc = CRC_INIT;
          end
        end
        T_SOP1: begin
          ch_valid = 1'b1;
          ch_data  = CH_DLE;
          if (ch_ready) s_nxt.ts = T_SOP2;
        end
        T_SOP2: begin
          ch_valid = 1'b1;
          ch_data  = CH_STX;
          if (ch_ready) s_nxt.ts = T_DATA;
        end
        T_DATA: begin
          ch_valid = src_valid;
          ch_data  = src_data;
          if (src_valid && ch_ready) begin
            take          = 1'b1;
            s_nxt.tx_last = src_last;
            s_nxt.tx_sum  = s_r.tx_sum + src_data;
            s_nxt.tx_crc  = crc_upd(s_r.tx_crc, src_data);
            if (src_data == CH_DLE) s_nxt.ts = T_DUP;
            else if (src_last) s_nxt.ts = T_EOP1;
          end
        end
        T_DUP: begin
          ch_valid = 1'b1;
          ch_data  = CH_DLE;
          if (ch_ready) s_nxt.ts = s_r.tx_last ? T_EOP1 : T_DATA;
        end
        T_EOP1: begin
          ch_valid = 1'b1;
          ch_data  = CH_DLE;
          if (ch_ready) s_nxt.ts = T_EOP2;
        end
        T_EOP2: begin
          ch_valid = 1'b1;
          ch_data  = CH_ETX;
          if (ch_ready) begin
            s_nxt.tx_crc = crc_upd(s_r.tx_crc, CH_ETX);
            s_nxt.ts     = T_CHK1;
          end
        end
        T_CHK1: begin
          ch_valid = 1'b1;
          ch_data  = crc_mode ? s_r.tx_crc[7:0]
                              : (~s_r.tx_sum + 8'h01);
          if (ch_ready) begin
            s_nxt.ts = crc_mode ? T_CHK2 : T_IDLE;
            s_nxt.wait_res = !crc_mode;
          end
        end
        T_CHK2: begin
          ch_valid = 1'b1;
          ch_data  = s_r.tx_crc[15:8];
          if (ch_ready) begin
            s_nxt.ts       = T_IDLE;
            s_nxt.wait_res = 1'b1;
          end
        end
        default: s_nxt.ts = T_IDLE;
      endcase
    end
    // receiver: split message codes from response codes
    if (rx_valid && proto_full) begin
      if (rx_err && (s_r.rs != R_IDLE) && (s_r.rs != R_ESC0)) begin
        s_nxt.rx_bad = 1'b1;
      end
      case (s_r.rs)
        R_IDLE: begin
          if (rx_data == CH_DLE) s_nxt.rs = R_ESC0;
        end
        R_ESC0: begin
          s_nxt.rs = R_IDLE;
          if (rx_data == CH_STX) begin
            s_nxt.rs     = R_DATA;
            s_nxt.rx_sum = SUM_INIT;
            s_nxt.rx_crc = CRC_INIT;
            s_nxt.rx_len = 8'h00;
            s_nxt.rx_ovf = 1'b0;
            s_nxt.rx_bad = rx_err;
          end else begin
            s_nxt = rx_rsp(s_nxt, rx_data);
          end
        end
        R_DATA: begin
          if (rx_data == CH_DLE) s_nxt.rs = R_ESC1;
          else s_nxt = rx_pay(s_nxt, rx_data);
        end
        R_ESC1: begin
          s_nxt.rs = R_DATA;
          if (rx_data == CH_DLE) begin
            s_nxt = rx_pay(s_nxt, rx_data);
          end else if (rx_data == CH_ETX) begin
            s_nxt.rx_crc = crc_upd(s_r.rx_crc, CH_ETX);
            s_nxt.rs     = R_CHK1;
          end else if (is_resp(rx_data) || (rx_data == CH_ENQ)) begin
            s_nxt = rx_rsp(s_nxt, rx_data);
          end else begin
            s_nxt = rx_end(s_nxt, 1'b0, sink_full);
          end
        end
        R_CHK1: begin
          if (crc_mode) begin
            s_nxt.chk_lo = rx_data;
            s_nxt.rs     = R_CHK2;
          end else begin
            s_nxt = rx_end(s_nxt, (s_r.rx_sum + rx_data) == 8'h00,
                           sink_full);
          end
        end
        R_CHK2: begin
          s_nxt = rx_end(s_nxt, {rx_data, s_r.chk_lo} == s_r.rx_crc,
                         sink_full);
        end
        default: s_nxt.rs = R_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      s_r <= FR_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ---------------------------------------------------------------
  // character unit
  // ---------------------------------------------------------------
  char_unit u_char (
    .sys_clk   (sys_clk),
    .reset_n   (reset_n),
    .parity_en (parity_en),
    .tx_valid  (ch_valid),
    .tx_data   (ch_data),
    .tx_ready  (ch_ready),
    .ser_tx    (ser_tx),
    .ser_rx    (ser_rx),
    .rx_valid  (rx_valid),
    .rx_data   (rx_data),
    .rx_err    (rx_err)
  );

  // outputs
  assign src_ready = take;
  assign snk_valid = s_r.snk_valid;
  assign snk_data  = s_r.snk_data;
  assign pkt_good  = s_r.pkt_good;
  assign pkt_bad   = s_r.pkt_bad;
  assign res_valid = s_r.res_valid;
  assign res_ack   = s_r.res_ack;
  assign tx_wait   = s_r.wait_res;

endmodule // fullduplex_link_framer

//--- include/link_pkg.sv
// Purpose: shared constants, codes, states and check functions of the
//          character link framer
// Assumes: 10 MHz system clock, byte-wide character unit
// Notes:   all control codes are seven-bit codes widened with bit 7 zero
package link_pkg;

  // ---------------------------------------------------------------
  // control characters
  // ---------------------------------------------------------------
  localparam logic [7:0] CH_STX = 8'h02;
  localparam logic [7:0] CH_ETX = 8'h03;
  localparam logic [7:0] CH_ENQ = 8'h05;
  localparam logic [7:0] CH_ACK = 8'h06;
  localparam logic [7:0] CH_DLE = 8'h10;
  localparam logic [7:0] CH_NAK = 8'h15;

  // ---------------------------------------------------------------
  // timing and limits
  // ---------------------------------------------------------------
  localparam int          CLK_HZ   = 10_000_000;
  localparam int          BAUD_HZ  = 115_200;
  localparam logic [10:0] BIT_CYC  = 11'(CLK_HZ / BAUD_HZ);
  localparam logic [10:0] HALF_CYC = 11'(CLK_HZ / BAUD_HZ / 2);
  localparam logic [3:0]  NBITS_P  = 4'hb;  // start, 8 data, parity, stop
  localparam logic [3:0]  NBITS_N  = 4'ha;  // start, 8 data, stop
  localparam logic [7:0]  MSG_MIN  = 8'h06;
  localparam logic [7:0]  MSG_MAX  = 8'hfa;

  // ---------------------------------------------------------------
  // reset values and check constants
  // ---------------------------------------------------------------
  localparam logic [15:0] CRC_POLY = 16'ha001;
  localparam logic [15:0] CRC_INIT = 16'h0000;
  localparam logic [7:0]  SUM_INIT = 8'h00;
  localparam logic [7:0]  RSP_INIT = CH_NAK; // answer to an early enquiry

  // ---------------------------------------------------------------
  // state encodings
  // ---------------------------------------------------------------
  typedef enum logic [8:0] {
    T_IDLE = 9'h001, T_SOP1 = 9'h002, T_SOP2 = 9'h004,
    T_DATA = 9'h008, T_DUP  = 9'h010, T_EOP1 = 9'h020,
    T_EOP2 = 9'h040, T_CHK1 = 9'h080, T_CHK2 = 9'h100
  } tx_state_t;

  typedef enum logic [5:0] {
    R_IDLE = 6'h01, R_ESC0 = 6'h02, R_DATA = 6'h04,
    R_ESC1 = 6'h08, R_CHK1 = 6'h10, R_CHK2 = 6'h20
  } rx_state_t;

  // one byte into the reflected sixteen-bit check, low bit first
  function automatic logic [15:0] crc_upd(logic [15:0] c, logic [7:0] b);
    logic [15:0] r;
    r = c ^ {8'h00, b};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction

  // acknowledge or negative acknowledge
  function automatic logic is_resp(logic [7:0] b);
    return (b == CH_ACK) || (b == CH_NAK);
  endfunction

endpackage

//--- src/char_unit.sv
// Purpose: one start bit, eight data bits low first, optional even
//          parity, one stop bit, in both directions
// Assumes: line idles high; rx pin is asynchronous to sys_clk
// Notes:   a bad stop or parity bit still delivers the byte, flagged
`timescale 1ns/1ps
module char_unit
  import link_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       reset_n,
  input  wire logic       parity_en,
  input  wire logic       tx_valid,
  input  wire logic [7:0] tx_data,
  output logic            tx_ready,
  output logic            ser_tx,
  input  wire logic       ser_rx,
  output logic            rx_valid,
  output logic [7:0]      rx_data,
  output logic            rx_err
);

  typedef struct packed {
    logic [2:0]  sync;
    logic        lvl;
    logic        t_busy;
    logic [10:0] t_cnt;
    logic [3:0]  t_left;
    logic [10:0] t_sh;
    logic        r_busy;
    logic [10:0] r_cnt;
    logic [3:0]  r_left;
    logic [10:0] r_sh;
    logic        r_valid;
    logic [7:0]  r_data;
    logic        r_err;
  } ch_t;

  localparam ch_t CH_RST = '{sync: 3'h7, lvl: 1'b1, t_sh: 11'h7ff,
                             default: '0};

  ch_t s_r;
  ch_t s_nxt;
  logic [10:0] sh;

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;
    sh    = s_r.r_sh;
    s_nxt.r_valid = 1'b0;
    // three-stage pin sampler, level moves when stages 2 and 3 agree
    s_nxt.sync = {s_r.sync[1:0], ser_rx};
    if (s_r.sync[2] == s_r.sync[1]) begin
      s_nxt.lvl = s_r.sync[2];
    end
    // transmit shifter
    if (!s_r.t_busy) begin
      if (tx_valid) begin
        s_nxt.t_busy = 1'b1;
        s_nxt.t_cnt  = BIT_CYC - 11'h001;
        s_nxt.t_left = parity_en ? NBITS_P : NBITS_N;
        s_nxt.t_sh   = {1'b1, parity_en ? ^tx_data : 1'b1,
                        tx_data, 1'b0};
      end
    end else if (s_r.t_cnt == 11'h000) begin
      s_nxt.t_cnt  = BIT_CYC - 11'h001;
      s_nxt.t_sh   = {1'b1, s_r.t_sh[10:1]};
      s_nxt.t_left = s_r.t_left - 4'h1;
      if (s_r.t_left == 4'h1) begin
        s_nxt.t_busy = 1'b0;
      end
    end else begin
      s_nxt.t_cnt = s_r.t_cnt - 11'h001;
    end
    // receive sampler, mid-bit
    if (!s_r.r_busy) begin
      if (!s_r.lvl) begin
        s_nxt.r_busy = 1'b1;
        s_nxt.r_cnt  = HALF_CYC;
        s_nxt.r_left = parity_en ? NBITS_P : NBITS_N;
      end
    end else if (s_r.r_cnt == 11'h000) begin
      sh = {s_r.lvl, s_r.r_sh[10:1]};
      s_nxt.r_sh   = sh;
      s_nxt.r_cnt  = BIT_CYC - 11'h001;
      s_nxt.r_left = s_r.r_left - 4'h1;
      if (s_r.lvl && (s_r.r_left == (parity_en ? NBITS_P : NBITS_N))) begin
        s_nxt.r_busy = 1'b0; // glitch, not a start bit
      end else if (s_r.r_left == 4'h1) begin
        s_nxt.r_busy  = 1'b0;
        s_nxt.r_valid = 1'b1;
        s_nxt.r_data  = parity_en ? sh[8:1] : sh[9:2];
        s_nxt.r_err   = !sh[10] ||
                        (parity_en && (sh[9] != ^sh[8:1]));
      end
    end else begin
      s_nxt.r_cnt = s_r.r_cnt - 11'h001;
    end
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      s_r <= CH_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  // outputs
  assign tx_ready = !s_r.t_busy;
  assign ser_tx   = s_r.t_sh[0];
  assign rx_valid = s_r.r_valid;
  assign rx_data  = s_r.r_data;
  assign rx_err   = s_r.r_err;

endmodule // char_unit

//--- testbench/link_checker.sv
// Purpose: port-level assertions for the link framer
// Assumes: one clock domain, asynchronous active-low reset
// Notes:   bound to every framer instance at the foot of this file
`timescale 1ns/1ps
module link_checker
  import link_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic ser_tx,
  input wire logic src_valid,
  input wire logic src_ready,
  input wire logic snk_valid,
  input wire logic pkt_good,
  input wire logic pkt_bad,
  input wire logic res_valid,
  input wire logic res_ack,
  input wire logic tx_wait
);
  localparam int LO_MAX = 9 * int'(BIT_CYC);
  logic [15:0] lo_cnt_r;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  // length of the current low run on the outgoing line
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) lo_cnt_r <= 16'h0000;
    else lo_cnt_r <= ser_tx ? 16'h0000 : lo_cnt_r + 16'h0001;
  end

  // ---------------------------------------------------------------
  // sequences and properties
  // ---------------------------------------------------------------
  sequence s_src_quiet;
    !src_ready [*8];
  endsequence

  sequence s_no_verdict;
    !(pkt_good || pkt_bad) [*8];
  endsequence

  a_ready_with_valid: assert property (src_ready |-> src_valid)
    else $error("source byte taken without valid");
  a_wait_blocks_src: assert property (tx_wait |-> !src_ready)
    else $error("source byte taken while awaiting answer");
  a_src_byte_gap: assert property (src_ready |=> s_src_quiet)
    else $error("source bytes taken faster than characters");
  a_verdict_excl: assert property (!(pkt_good && pkt_bad))
    else $error("packet judged good and bad at once");
  a_verdict_once: assert property ((pkt_good || pkt_bad) |=> s_no_verdict)
    else $error("packet verdict repeated");
  a_sink_byte_pulse: assert property (snk_valid |=> !snk_valid)
    else $error("sink byte strobe longer than one cycle");
  a_result_ends_wait: assert property (
    res_valid |-> !tx_wait && $past(tx_wait))
    else $error("answer reported outside waiting state");
  a_result_holds: assert property (!res_valid |-> $stable(res_ack))
    else $error("answer kind changed without a new answer");
  a_bit_length: assert property (
    $rose(ser_tx) |-> (lo_cnt_r % BIT_CYC) == 16'h0000)
    else $error("low run not a whole number of bit times");
  a_stop_bit: assert property (int'(lo_cnt_r) <= LO_MAX)
    else $error("line low longer than start plus eight bits");
endmodule // link_checker

bind fullduplex_link_framer link_checker u_link_checker (
  .sys_clk(sys_clk), .reset_n(reset_n), .ser_tx(ser_tx),
  .src_valid(src_valid), .src_ready(src_ready), .snk_valid(snk_valid),
  .pkt_good(pkt_good), .pkt_bad(pkt_bad), .res_valid(res_valid),
  .res_ack(res_ack), .tx_wait(tx_wait)
);

//--- testbench/host_link.sv
// Purpose: behavioural host at the far end of the serial line
// Assumes: no parity, one stop bit, same bit time as the framer
// Notes:   received responses are kept apart from message codes
`timescale 1ns/1ps
module host_link
  import link_pkg::*;
(
  input  wire logic sys_clk,
  input  wire logic reset_n,
  input  wire logic ser_tx,
  output logic      ser_rx
);
  logic [7:0] tx_q[$];
  logic [7:0] msg_q[$];
  logic [7:0] resp_q[$];
  int         frame_err;
  int         chk_len = 1;  // check field bytes after the close

  // waits whole clock cycles
  task automatic cyc_wait(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  // ---------------------------------------------------------------
  // sender: queued bytes go out back to back, idle high
  // ---------------------------------------------------------------
  initial begin
    logic [7:0] b;
    ser_rx = 1'b1;
    forever begin
      @(posedge sys_clk);
      if (reset_n && tx_q.size() != 0) begin
        b = tx_q.pop_front();
        ser_rx <= 1'b0;
        cyc_wait(int'(BIT_CYC));
        for (int i = 0; i < 8; i++) begin
          ser_rx <= b[i];
          cyc_wait(int'(BIT_CYC));
        end
        ser_rx <= 1'b1;
        cyc_wait(int'(BIT_CYC) - 1);
      end
    end
  end

  // receiver with separator; check field bytes are passed on raw
  initial begin
    logic [7:0] b;
    logic       esc;
    int         raw;
    esc = 1'b0;
    raw = 0;
    frame_err = 0;
    forever begin
      @(negedge ser_tx);
      cyc_wait(int'(HALF_CYC));
      for (int i = 0; i < 8; i++) begin
        cyc_wait(int'(BIT_CYC));
        b[i] = ser_tx;
      end
      cyc_wait(int'(BIT_CYC));
      if (ser_tx !== 1'b1) frame_err++;
      if (raw != 0) begin
        msg_q.push_back(b);
        raw--;
      end else begin
        if (esc && (b == 8'h06 || b == 8'h15)) begin
          resp_q.push_back(b);
        end else if (esc) begin
          msg_q.push_back(8'h10);
          msg_q.push_back(b);
        end else if (b != 8'h10) begin
          msg_q.push_back(b);
        end
        if (esc && b == 8'h03) raw = chk_len;
        esc = !esc && (b == 8'h10);
      end
    end
  end
endmodule // host_link

//--- testbench/fullduplex_link_framer_tb.sv
// Purpose: self-checking bench of the link framer against a host
// Assumes: bit time from the package, no parity on the line
// Notes:   both directions run at once to keep the run short
`timescale 1ns/1ps
`define CHECK(what, exp, got) \
  begin \
    comparisons++; \
    if ((got) !== (exp)) begin \
      err_total++; \
      $display("Error %s expected %h seen %h", what, exp, got); \
    end \
  end
module fullduplex_link_framer_tb
  import link_pkg::*;
;
  typedef logic [7:0] byte_q_t[$];
  localparam int WAIT_MAX = 30000;

  logic       sys_clk;
  logic       reset_n;
  logic       proto_full;
  logic       crc_mode;
  logic       parity_en;
  logic       ser_rx;
  logic       ser_tx;
  logic       src_valid;
  logic [7:0] src_data;
  logic       src_last;
  logic       src_ready;
  logic       sink_full;
  logic       snk_valid;
  logic [7:0] snk_data;
  logic       pkt_good;
  logic       pkt_bad;
  logic       res_valid;
  logic       res_ack;
  logic       tx_wait;
  int         err_total;
  int         comparisons;
  int         good_cnt;
  int         bad_cnt;
  int         res_cnt;
  logic [7:0] snk_q[$];
  logic [7:0] src_msg[6] = '{8'h01, 8'h10, 8'h7f, 8'h80, 8'hff, 8'h00};
  logic [7:0] host_msg[6] = '{8'h10, 8'h02, 8'h03, 8'h05, 8'h06, 8'h15};

  fullduplex_link_framer dut (.sys_clk(sys_clk), .reset_n(reset_n),
    .proto_full(proto_full), .crc_mode(crc_mode), .parity_en(parity_en),
    .ser_rx(ser_rx), .ser_tx(ser_tx), .src_valid(src_valid),
    .src_data(src_data), .src_last(src_last), .src_ready(src_ready),
    .sink_full(sink_full), .snk_valid(snk_valid), .snk_data(snk_data),
    .pkt_good(pkt_good), .pkt_bad(pkt_bad), .res_valid(res_valid),
    .res_ack(res_ack), .tx_wait(tx_wait));
  host_link host (.sys_clk(sys_clk), .reset_n(reset_n), .ser_tx(ser_tx),
    .ser_rx(ser_rx));

  always #50 sys_clk = ~sys_clk;

  // collects what the framer reports
  always @(negedge sys_clk) begin
    if (snk_valid === 1'b1) snk_q.push_back(snk_data);
    if (pkt_good === 1'b1) good_cnt++;
    if (pkt_bad === 1'b1) bad_cnt++;
    if (res_valid === 1'b1) res_cnt++;
  end

  // wire image of one packet with its block check or crc field
  function automatic byte_q_t encode(input logic [7:0] m[6], input bit crc);
    byte_q_t     q;
    logic [7:0]  sum;
    logic [15:0] c;
    logic [7:0]  p[7];
    sum = 8'h00;
    c = 16'h0000;
    q.push_back(8'h10);
    q.push_back(8'h02);
    foreach (m[i]) begin
      q.push_back(m[i]);
      if (m[i] == 8'h10) q.push_back(8'h10);
      sum = sum + m[i];
      p[i] = m[i];
    end
    p[6] = 8'h03;
    foreach (p[i]) begin
      c = c ^ {8'h00, p[i]};
      repeat (8) c = c[0] ? ((c >> 1) ^ 16'ha001) : (c >> 1);
    end
    q.push_back(8'h10);
    q.push_back(8'h03);
    if (crc) begin
      q.push_back(c[7:0]);
      q.push_back(c[15:8]);
    end else begin
      q.push_back(8'h00 - sum);
    end
    return q;
  endfunction

  // prints the verdict and ends the run
  task automatic summarize();
    if (err_total == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // outputs while reset is held
  task automatic reset_state();
    repeat (4) @(posedge sys_clk);
    `CHECK("ser_tx", 1'b1, ser_tx)
    `CHECK("src_ready", 1'b0, src_ready)
    `CHECK("tx_wait", 1'b0, tx_wait)
  endtask

  // enquiry first, then packets both ways, then the host's answer
  task automatic duplex_exchange();
    byte_q_t exp_q;
    int      n;
    exp_q = encode(host_msg, 1'b0);
    host.tx_q.push_back(8'h10);
    host.tx_q.push_back(8'h05);
    foreach (exp_q[i]) host.tx_q.push_back(exp_q[i]);
    send_src(src_msg);
    for (n = 0; n < WAIT_MAX && tx_wait !== 1'b1; n++) @(negedge sys_clk);
    host.tx_q.push_back(8'h10);
    host.tx_q.push_back(8'h06);
    for (n = 0; n < WAIT_MAX && res_cnt < 1; n++) @(negedge sys_clk);
    `CHECK("result count", 1, res_cnt)
    `CHECK("res_ack", 1'b1, res_ack)
    `CHECK("tx_wait after answer", 1'b0, tx_wait)
    for (n = 0; n < WAIT_MAX && host.resp_q.size() < 2; n++)
      @(negedge sys_clk);
    exp_q = encode(src_msg, 1'b0);
    `CHECK("message code count", exp_q.size(), host.msg_q.size())
    foreach (exp_q[i]) `CHECK("message code", exp_q[i], host.msg_q[i])
    `CHECK("enquiry answer", 8'h15, host.resp_q[0])
    `CHECK("packet answer", 8'h06, host.resp_q[1])
    `CHECK("sink byte count", 6, snk_q.size())
    foreach (host_msg[i]) `CHECK("sink byte", host_msg[i], snk_q[i])
    `CHECK("good verdicts", 1, good_cnt)
    `CHECK("bad verdicts", 0, bad_cnt)
    `CHECK("host framing errors", 0, host.frame_err)
  endtask

  // offers one message to the source port, each byte held until taken
  task automatic send_src(input logic [7:0] m[6]);
    int n;
    for (int i = 0; i < 6; i++) begin
      src_valid <= 1'b1;
      src_data <= m[i];
      src_last <= (i == 5);
      n = 0;
      do begin
        @(negedge sys_clk);
        n++;
      end while (src_ready !== 1'b1 && n < WAIT_MAX);
      @(posedge sys_clk);
    end
    src_valid <= 1'b0;
    src_last <= 1'b0;
  endtask

  // half duplex selected: no packet starts, line codes are ignored
  task automatic half_duplex_idle();
    int n;
    @(posedge sys_clk);
    proto_full <= 1'b0;
    src_valid <= 1'b1;
    host.resp_q.delete();
    host.tx_q.push_back(8'h10);
    host.tx_q.push_back(8'h05);
    n = 0;
    repeat (50 * int'(BIT_CYC)) @(negedge sys_clk) n += int'(src_ready);
    `CHECK("half duplex takes", 0, n)
    `CHECK("half duplex answers", 0, host.resp_q.size())
    @(posedge sys_clk);
    src_valid <= 1'b0;
    proto_full <= 1'b1;
  endtask

  // crc field both ways with the sink full: bytes arrive, packet refused
  task automatic crc_full_exchange();
    byte_q_t exp_q;
    int      n;
    @(posedge sys_clk);
    crc_mode <= 1'b1;
    sink_full <= 1'b1;
    host.chk_len = 2;
    host.msg_q.delete();
    host.resp_q.delete();
    snk_q.delete();
    good_cnt = 0;
    bad_cnt = 0;
    res_cnt = 0;
    exp_q = encode(host_msg, 1'b1);
    foreach (exp_q[i]) host.tx_q.push_back(exp_q[i]);
    send_src(src_msg);
    for (n = 0; n < WAIT_MAX && tx_wait !== 1'b1; n++) @(negedge sys_clk);
    host.tx_q.push_back(8'h10);
    host.tx_q.push_back(8'h15);
    for (n = 0; n < WAIT_MAX && res_cnt < 1; n++) @(negedge sys_clk);
    `CHECK("crc result count", 1, res_cnt)
    `CHECK("crc res_ack", 1'b0, res_ack)
    for (n = 0; n < WAIT_MAX && host.resp_q.size() < 1; n++)
      @(negedge sys_clk);
    exp_q = encode(src_msg, 1'b1);
    `CHECK("crc code count", exp_q.size(), host.msg_q.size())
    foreach (exp_q[i]) `CHECK("crc code", exp_q[i], host.msg_q[i])
    `CHECK("full sink answer", 8'h15, host.resp_q[0])
    `CHECK("crc sink byte count", 6, snk_q.size())
    `CHECK("full sink bad verdicts", 1, bad_cnt)
    `CHECK("full sink good verdicts", 0, good_cnt)
  endtask

  // main sequence
  initial begin
    sys_clk = 1'b0;
    reset_n = 1'b0;
    proto_full = 1'b1;
    crc_mode = 1'b0;
    parity_en = 1'b0;
    sink_full = 1'b0;
    src_valid = 1'b0;
    src_data = 8'h00;
    src_last = 1'b0;
    err_total = 0;
    comparisons = 0;
    good_cnt = 0;
    bad_cnt = 0;
    res_cnt = 0;
    reset_state();
    repeat (8) @(posedge sys_clk);
    reset_n <= 1'b1;
    duplex_exchange();
    half_duplex_idle();
    crc_full_exchange();
    summarize();
  end

  // watchdog: all scenarios need about forty character times
  initial begin
    repeat (90000) @(posedge sys_clk);
    err_total++;
    summarize();
  end
endmodule // fullduplex_link_framer_tb
